// ==== design/rlt_pkg.sv ====
/*
  rlt_pkg: shared constants and types for the logical/transport packet router.
  Assumes a single clock domain and 64-bit packet beats with a start/end marker.
*/
package rlt_pkg;

  localparam int RLT_DATA_W = 64;
  localparam int RLT_ID_W_SMALL = 8;
  localparam int RLT_ID_W_LARGE = 16;

  // header layout of the first beat of every packet
  localparam int RLT_FTYPE_LSB = 56;
  localparam int RLT_FTYPE_W = 4;
  localparam int RLT_SRC_ID_LSB = 32;
  localparam int RLT_DST_ID_LSB = 16;

  // format type codes
  localparam logic [3:0] RLT_FT_MAINT = 4'h8;
  localparam logic [3:0] RLT_FT_RESP = 4'hd;

  // source id loaded at reset; replaced by src_id on the first clock after reset
  localparam logic [15:0] RLT_SRC_ID_RESET = 16'h0000;

  // outbound source select
  typedef enum logic [1:0] {
    RLT_SRC_IREQ = 2'b00,
    RLT_SRC_TRSP = 2'b01,
    RLT_SRC_MNT = 2'b10
  } rlt_src_t;

  // inbound destination select
  typedef enum logic [1:0] {
    RLT_DST_IRSP = 2'b00,
    RLT_DST_TREQ = 2'b01,
    RLT_DST_MNT = 2'b10
  } rlt_dst_t;

  typedef enum logic [1:0] {
    RLT_ST_IDLE = 2'b00,
    RLT_ST_PKT = 2'b01
  } rlt_state_t;

endpackage : rlt_pkg

// ==== design/rlt_stream_if.sv ====
/*
  rlt_stream_if: one-way packet stream with valid/ready handshake and
  start/end markers. Assumes both ends sit on the same clock.
*/
`timescale 1ns/1ps
interface rlt_stream_if #(
  parameter int DW = 64
);
  logic valid;
  logic ready;
  logic sop;
  logic eop;
  logic [DW-1:0] data;

  modport src (output valid, output sop, output eop, output data, input ready);
  modport snk (input valid, input sop, input eop, input data, output ready);
endinterface : rlt_stream_if

// ==== design/rlt_tx_arb.sv ====
/*
  rlt_tx_arb: merges three outbound sources into one stream, packet at a time,
  stamping the source id into the first beat. Local config accesses are steered
  to the local output instead of the link only when they come from the initiator request port. Assumes sources hold beats until taken.
*/
`timescale 1ns/1ps
module rlt_tx_arb
  import rlt_pkg::*;
#(
  parameter int ID_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ID_W-1:0] src_id,
  input wire logic [ID_W-1:0] local_id,
  rlt_stream_if.snk ireq,
  rlt_stream_if.snk trsp,
  rlt_stream_if.snk mnt,
  rlt_stream_if.src link,
  rlt_stream_if.src loc
);

  rlt_state_t state;
  rlt_src_t sel;
  logic to_local;
  logic in_valid;
  logic in_sop;
  logic in_eop;
  logic [RLT_DATA_W-1:0] in_data;
  logic pick_valid;
  rlt_src_t pick;
  logic pick_local;
  logic [RLT_DATA_W-1:0] stamped;
  logic out_ready;
  logic fire;

  // local config access: maintenance request aimed at our own id
  function automatic logic is_local(input logic [RLT_DATA_W-1:0] hdr,
                                    input logic [ID_W-1:0] me);
    return (hdr[RLT_FTYPE_LSB +: RLT_FTYPE_W] == RLT_FT_MAINT) &&
           (hdr[RLT_DST_ID_LSB +: ID_W] == me);
  endfunction : is_local

  // fixed priority when idle; responses first so requests never starve them
  always_comb begin
    pick_valid = 1'b1;
    pick = RLT_SRC_TRSP;
    if (trsp.valid && trsp.sop) begin
      pick = RLT_SRC_TRSP;
    end else if (mnt.valid && mnt.sop) begin
      pick = RLT_SRC_MNT;
    end else if (ireq.valid && ireq.sop) begin
      pick = RLT_SRC_IREQ;
    end else begin
      pick_valid = 1'b0;
    end
  end

  // current input mux
  always_comb begin
    rlt_src_t s;
    s = (state == RLT_ST_IDLE) ? pick : sel;
    case (s)
      RLT_SRC_IREQ: begin
        in_valid = ireq.valid;
        in_sop = ireq.sop;
        in_eop = ireq.eop;
        in_data = ireq.data;
      end
      RLT_SRC_MNT: begin
        in_valid = mnt.valid;
        in_sop = mnt.sop;
        in_eop = mnt.eop;
        in_data = mnt.data;
      end
      default: begin
        in_valid = trsp.valid;
        in_sop = trsp.sop;
        in_eop = trsp.eop;
        in_data = trsp.data;
      end
    endcase
    if (state == RLT_ST_IDLE) begin
      in_valid = pick_valid;
    end
  end

  // local decision only from the initiator request port
  assign pick_local = (pick == RLT_SRC_IREQ) && is_local(in_data, local_id);
  assign to_local = (state == RLT_ST_IDLE) ? pick_local : 1'b0;

  // header beat gets our id stamped in
  always_comb begin
    stamped = in_data;
    if (in_sop) begin
      stamped[RLT_SRC_ID_LSB +: ID_W] = src_id;
    end
  end

  logic route_local;
  logic held_local;
  assign route_local = (state == RLT_ST_IDLE) ? to_local : held_local;
  assign out_ready = route_local ? loc.ready : link.ready;
  assign fire = in_valid && out_ready;

  // outbound is combinational pass-through so backpressure reaches the source
  assign link.valid = in_valid && !route_local;
  assign link.sop = in_sop;
  assign link.eop = in_eop;
  assign link.data = stamped;
  assign loc.valid = in_valid && route_local;
  assign loc.sop = in_sop;
  assign loc.eop = in_eop;
  assign loc.data = in_data;

  // ready back to the chosen source only
  always_comb begin
    rlt_src_t s;
    s = (state == RLT_ST_IDLE) ? pick : sel;
    ireq.ready = out_ready && (s == RLT_SRC_IREQ) && in_valid;
    trsp.ready = out_ready && (s == RLT_SRC_TRSP) && in_valid;
    mnt.ready = out_ready && (s == RLT_SRC_MNT) && in_valid;
  end

  // packet lock: hold the chosen source from its first offer until its last beat passes;
  // locking on offer, not on take, keeps a stalled beat from being swapped by a later source
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RLT_ST_IDLE;
      sel <= RLT_SRC_TRSP;
      held_local <= 1'b0;
    end else if (state == RLT_ST_IDLE) begin
      if (pick_valid) begin
        sel <= pick;
        held_local <= to_local;
        state <= (fire && in_eop) ? RLT_ST_IDLE : RLT_ST_PKT;
      end
    end else if (fire && in_eop) begin
      state <= RLT_ST_IDLE;
    end
  end

endmodule : rlt_tx_arb

// ==== design/rlt_rx_route.sv ====
/*
  rlt_rx_route: steers each inbound packet from the link to exactly one of
  three sinks by its format type. Assumes the link holds beats until taken.
*/
`timescale 1ns/1ps
module rlt_rx_route
  import rlt_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  rlt_stream_if.snk link,
  rlt_stream_if.src irsp,
  rlt_stream_if.src treq,
  rlt_stream_if.src mnt
);

  rlt_state_t state;
  rlt_dst_t held;
  rlt_dst_t dst;
  logic dst_ready;

  // unknown and user types fall to the target request port, never dropped
  function automatic rlt_dst_t classify(input logic [RLT_FTYPE_W-1:0] ft);
    case (ft)
      RLT_FT_RESP: return RLT_DST_IRSP;
      RLT_FT_MAINT: return RLT_DST_MNT;
      default: return RLT_DST_TREQ;
    endcase
  endfunction : classify

  assign dst = (state == RLT_ST_IDLE) ? classify(link.data[RLT_FTYPE_LSB +: RLT_FTYPE_W]) : held;

  // one sink sees valid; the others stay quiet
  assign irsp.valid = link.valid && (dst == RLT_DST_IRSP);
  assign treq.valid = link.valid && (dst == RLT_DST_TREQ);
  assign mnt.valid = link.valid && (dst == RLT_DST_MNT);
  assign irsp.sop = link.sop;
  assign treq.sop = link.sop;
  assign mnt.sop = link.sop;
  assign irsp.eop = link.eop;
  assign treq.eop = link.eop;
  assign mnt.eop = link.eop;
  assign irsp.data = link.data;
  assign treq.data = link.data;
  assign mnt.data = link.data;

  // stall the link while the chosen sink is busy
  always_comb begin
    case (dst)
      RLT_DST_IRSP: dst_ready = irsp.ready;
      RLT_DST_MNT: dst_ready = mnt.ready;
      default: dst_ready = treq.ready;
    endcase
  end
  assign link.ready = dst_ready;

  // remember destination across the body of a packet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RLT_ST_IDLE;
      held <= RLT_DST_TREQ;
    end else if (link.valid && dst_ready) begin
      if (state == RLT_ST_IDLE) begin
        held <= dst;
      end
      state <= link.eop ? RLT_ST_IDLE : RLT_ST_PKT;
    end
  end

endmodule : rlt_rx_route

// ==== design/rlt_router.sv ====
/*
  rlt_router: logical/transport router top. Joins four user ports, a
  maintenance request/response port and a local config port to a one-way
  transmit stream and a one-way receive stream toward the packet buffer.
  Assumes every port is in the clk domain and follows valid/ready.
*/
// Behaviour
// - outbound packets are taken from initiator request, target response and maintenance.
// - every outbound packet goes to the link transmit stream except local config accesses from the initiator request port.
// - local config reads and writes from the initiator request port go to the local config port instead.
// - each inbound packet is delivered to exactly one of initiator response, target request or maintenance.
// - the link is a separate transmit stream and receive stream, each with its own handshake.
// - maintenance offers a request/response pair and a config register port for local config accesses only, fed from the initiator request port.
// - packet data is 64 bits wide in both directions.
// - the programmed source id is written into the header of every packet sent on the link.
// - a build option widens device ids in headers to 16 bits.
// - transmit and receive paths run side by side and never block each other.
// - a beat moves only in a cycle where valid and ready are both high.
// - the user side has four ports, two sourcing and two sinking packets.
// - doorbell and message types pass like reads and writes.
// - unknown format types reach the user ports and are never dropped.
`timescale 1ns/1ps
module rlt_router
  import rlt_pkg::*;
#(
  parameter bit LARGE_SYS = 1'b0,
  parameter int ID_W = LARGE_SYS ? RLT_ID_W_LARGE : RLT_ID_W_SMALL
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ID_W-1:0] src_id,
  // initiator request (user sources)
  input wire logic ireq_valid,
  output logic ireq_ready,
  input wire logic ireq_sop,
  input wire logic ireq_eop,
  input wire logic [RLT_DATA_W-1:0] ireq_data,
  // target response (user sources)
  input wire logic trsp_valid,
  output logic trsp_ready,
  input wire logic trsp_sop,
  input wire logic trsp_eop,
  input wire logic [RLT_DATA_W-1:0] trsp_data,
  // initiator response (user sinks)
  output logic irsp_valid,
  input wire logic irsp_ready,
  output logic irsp_sop,
  output logic irsp_eop,
  output logic [RLT_DATA_W-1:0] irsp_data,
  // target request (user sinks)
  output logic treq_valid,
  input wire logic treq_ready,
  output logic treq_sop,
  output logic treq_eop,
  output logic [RLT_DATA_W-1:0] treq_data,
  // maintenance request in
  input wire logic mreq_valid,
  output logic mreq_ready,
  input wire logic mreq_sop,
  input wire logic mreq_eop,
  input wire logic [RLT_DATA_W-1:0] mreq_data,
  // maintenance response out (inbound maintenance)
  output logic mrsp_valid,
  input wire logic mrsp_ready,
  output logic mrsp_sop,
  output logic mrsp_eop,
  output logic [RLT_DATA_W-1:0] mrsp_data,
  // config register port: local config accesses from the initiator request port
  output logic cfg_valid,
  input wire logic cfg_ready,
  output logic cfg_sop,
  output logic cfg_eop,
  output logic [RLT_DATA_W-1:0] cfg_data,
  // link transmit stream to buffer
  output logic ltx_valid,
  input wire logic ltx_ready,
  output logic ltx_sop,
  output logic ltx_eop,
  output logic [RLT_DATA_W-1:0] ltx_data,
  // link receive stream from buffer
  input wire logic lrx_valid,
  output logic lrx_ready,
  input wire logic lrx_sop,
  input wire logic lrx_eop,
  input wire logic [RLT_DATA_W-1:0] lrx_data
);

  rlt_stream_if #(.DW(RLT_DATA_W)) ireq_s ();
  rlt_stream_if #(.DW(RLT_DATA_W)) trsp_s ();
  rlt_stream_if #(.DW(RLT_DATA_W)) mreq_s ();
  rlt_stream_if #(.DW(RLT_DATA_W)) ltx_s ();
  rlt_stream_if #(.DW(RLT_DATA_W)) cfg_s ();
  rlt_stream_if #(.DW(RLT_DATA_W)) lrx_s ();
  rlt_stream_if #(.DW(RLT_DATA_W)) irsp_s ();
  rlt_stream_if #(.DW(RLT_DATA_W)) treq_s ();
  rlt_stream_if #(.DW(RLT_DATA_W)) mrsp_s ();

  logic [ID_W-1:0] sid;

  // source id is registered every cycle, so a change reaches the header stamp one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sid <= RLT_SRC_ID_RESET[ID_W-1:0];
    end else begin
      sid <= src_id;
    end
  end

  // user and maintenance sources onto interfaces; doorbell and message ride unchanged
  assign ireq_s.valid = ireq_valid;
  assign ireq_s.sop = ireq_sop;
  assign ireq_s.eop = ireq_eop;
  assign ireq_s.data = ireq_data;
  assign ireq_ready = ireq_s.ready;
  assign trsp_s.valid = trsp_valid;
  assign trsp_s.sop = trsp_sop;
  assign trsp_s.eop = trsp_eop;
  assign trsp_s.data = trsp_data;
  assign trsp_ready = trsp_s.ready;
  assign mreq_s.valid = mreq_valid;
  assign mreq_s.sop = mreq_sop;
  assign mreq_s.eop = mreq_eop;
  assign mreq_s.data = mreq_data;
  assign mreq_ready = mreq_s.ready;

  // transmit side
  assign ltx_valid = ltx_s.valid;
  assign ltx_sop = ltx_s.sop;
  assign ltx_eop = ltx_s.eop;
  assign ltx_data = ltx_s.data;
  assign ltx_s.ready = ltx_ready;
  assign cfg_valid = cfg_s.valid;
  assign cfg_sop = cfg_s.sop;
  assign cfg_eop = cfg_s.eop;
  assign cfg_data = cfg_s.data;
  assign cfg_s.ready = cfg_ready;

  // receive side, separate bus with its own handshake
  assign lrx_s.valid = lrx_valid;
  assign lrx_s.sop = lrx_sop;
  assign lrx_s.eop = lrx_eop;
  assign lrx_s.data = lrx_data;
  assign lrx_ready = lrx_s.ready;
  assign irsp_valid = irsp_s.valid;
  assign irsp_sop = irsp_s.sop;
  assign irsp_eop = irsp_s.eop;
  assign irsp_data = irsp_s.data;
  assign irsp_s.ready = irsp_ready;
  assign treq_valid = treq_s.valid;
  assign treq_sop = treq_s.sop;
  assign treq_eop = treq_s.eop;
  assign treq_data = treq_s.data;
  assign treq_s.ready = treq_ready;
  assign mrsp_valid = mrsp_s.valid;
  assign mrsp_sop = mrsp_s.sop;
  assign mrsp_eop = mrsp_s.eop;
  assign mrsp_data = mrsp_s.data;
  assign mrsp_s.ready = mrsp_ready;

  // two independent engines, so neither direction waits on the other
  rlt_tx_arb #(.ID_W(ID_W)) u_tx (
    .clk(clk),
    .rst_n(rst_n),
    .src_id(sid),
    .local_id(sid),
    .ireq(ireq_s.snk),
    .trsp(trsp_s.snk),
    .mnt(mreq_s.snk),
    .link(ltx_s.src),
    .loc(cfg_s.src)
  );

  rlt_rx_route u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .link(lrx_s.snk),
    .irsp(irsp_s.src),
    .treq(treq_s.src),
    .mnt(mrsp_s.src)
  );

endmodule : rlt_router

// ==== tb/rlt_router_monitor.sv ====
/*
  rlt_router_monitor: concurrent checks on the router top ports.
  Assumes one clock domain and the pass-through timing of the router outputs.
*/
`timescale 1ns/1ps
module rlt_router_monitor
  import rlt_pkg::*;
#(
  parameter int ID_W = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ID_W-1:0] src_id,
  input wire logic ireq_valid,
  input wire logic ireq_ready,
  input wire logic lrx_valid,
  input wire logic lrx_ready,
  input wire logic lrx_sop,
  input wire logic [RLT_DATA_W-1:0] lrx_data,
  input wire logic irsp_valid,
  input wire logic irsp_ready,
  input wire logic [RLT_DATA_W-1:0] irsp_data,
  input wire logic treq_valid,
  input wire logic treq_ready,
  input wire logic mrsp_valid,
  input wire logic mrsp_ready,
  input wire logic ltx_valid,
  input wire logic ltx_ready,
  input wire logic ltx_sop,
  input wire logic [RLT_DATA_W-1:0] ltx_data,
  input wire logic cfg_valid,
  input wire logic cfg_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [3:0] ft;
  logic hdr;
  // header beat of an inbound packet and its format type
  assign ft = lrx_data[RLT_FTYPE_LSB +: RLT_FTYPE_W];
  assign hdr = lrx_valid && lrx_sop;
  AST_RX_RESP:
    assert property (hdr && ft == RLT_FT_RESP |-> irsp_valid && !treq_valid && !mrsp_valid)
    else $error("response packet misrouted");
  AST_RX_MAINT:
    assert property (hdr && ft == RLT_FT_MAINT |-> mrsp_valid && !irsp_valid && !treq_valid)
    else $error("maintenance packet misrouted");
  AST_RX_OTHER:
    assert property (hdr && ft != RLT_FT_RESP && ft != RLT_FT_MAINT |-> treq_valid && !irsp_valid)
    else $error("other packet not at target request");
  AST_RX_STALL:
    assert property (hdr && ft != RLT_FT_RESP && ft != RLT_FT_MAINT && !treq_ready |-> !lrx_ready)
    else $error("link beat taken while sink busy");
  AST_RX_ONE:
    assert property (lrx_valid && lrx_ready |->
      $onehot({irsp_valid && irsp_ready, treq_valid && treq_ready, mrsp_valid && mrsp_ready}))
    else $error("inbound beat not taken by exactly one sink");
  AST_RX_DATA:
    assert property (irsp_valid |-> lrx_valid && irsp_data == lrx_data)
    else $error("inbound data altered");
  AST_TX_STAMP:
    assert property (ltx_valid && ltx_sop |-> ltx_data[RLT_SRC_ID_LSB +: ID_W] == $past(src_id))
    else $error("source id not stamped");
  AST_TX_HOLD:
    assert property (ltx_valid && !ltx_ready |=> ltx_valid && $stable(ltx_data))
    else $error("stalled link beat dropped or changed");
  AST_TX_TAKE:
    assert property (ireq_valid && ireq_ready |-> ltx_valid && ltx_ready || cfg_valid && cfg_ready)
    else $error("request taken without a destination");
  AST_TX_EXCL:
    assert property (ltx_valid |-> !cfg_valid)
    else $error("packet offered to link and config at once");
endmodule : rlt_router_monitor

bind rlt_router rlt_router_monitor #(.ID_W(ID_W)) mon (.*);

// ==== tb/rlt_buf_model.sv ====
/*
  rlt_buf_model: packet buffer in front of the link, one sink and one source.
  Assumes callers enter send just after a rising clock edge.
*/
`timescale 1ns/1ps
module rlt_buf_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic ltx_valid,
  input wire logic [63:0] ltx_data,
  output logic ltx_ready,
  output logic lrx_valid,
  output logic lrx_sop,
  output logic lrx_eop,
  output logic [63:0] lrx_data,
  input wire logic lrx_ready
);
  logic [63:0] tx_q[$];
  initial begin
    ltx_ready = 1'b1;
    lrx_valid = 1'b0;
    lrx_sop = 1'b0;
    lrx_eop = 1'b0;
    lrx_data = 64'h0;
  end
  // a beat counts only when both sides agree; slow mode stalls every other cycle
  always @(posedge clk) begin
    if (ltx_valid && ltx_ready) tx_q.push_back(ltx_data);
    ltx_ready <= #1 !slow || !ltx_ready;
  end
  // receive beat held until taken; idle data is inverted so a stale value never matches
  task automatic send(input logic sop, input logic eop, input logic [63:0] d, output logic ok);
    int n;
    n = 0;
    lrx_valid = 1'b1;
    lrx_sop = sop;
    lrx_eop = eop;
    lrx_data = d;
    do begin
      @(posedge clk);
      n++;
    end while (!lrx_ready && n < 64);
    ok = (n < 64);
    #1;
    if (eop) begin
      lrx_valid = 1'b0;
      lrx_data = ~d;
      @(posedge clk);
      #1;
    end
  endtask : send
endmodule : rlt_buf_model

// ==== tb/rlt_router_test.sv ====
/*
  rlt_router_test: self-checking bench for the packet router.
  Assumes the router with 8-bit ids and the buffer model on the link side.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin logic [71:0] ca; logic [71:0] cb; ca = 72'(a); cb = 72'(b); \
  n_compared++; if (ca !== cb) begin miscompares++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, ca, cb); end end
module rlt_router_test;
  import rlt_pkg::*;
  localparam logic [7:0] SID = 8'h5a;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  logic ok;
  logic [7:0] src_id = SID;
  logic ireq_valid, ireq_ready, ireq_sop, ireq_eop, trsp_valid, trsp_ready, trsp_sop, trsp_eop;
  logic mreq_valid, mreq_ready, mreq_sop, mreq_eop, irsp_valid, irsp_ready, irsp_sop, irsp_eop;
  logic treq_valid, treq_ready, treq_sop, treq_eop, mrsp_valid, mrsp_ready, mrsp_sop, mrsp_eop;
  logic cfg_valid, cfg_ready, cfg_sop, cfg_eop, ltx_valid, ltx_ready, ltx_sop, ltx_eop;
  logic lrx_valid, lrx_ready, lrx_sop, lrx_eop;
  logic [63:0] ireq_data, trsp_data, mreq_data, irsp_data, treq_data, mrsp_data, cfg_data;
  logic [63:0] ltx_data, lrx_data;
  rlt_dst_t rx_q[$];
  logic [65:0] cfg_q[$];
  logic [65:0] rxd_q[$];
  logic [1:0] txm_q[$];
  int miscompares = 0;
  int n_compared = 0;
  rlt_router dut (.*);
  rlt_buf_model buf_m (.*);
  always #5 clk = ~clk;
  // log where every inbound beat and every config beat went
  always @(posedge clk) begin
    if (irsp_valid && irsp_ready) rx_q.push_back(RLT_DST_IRSP);
    if (treq_valid && treq_ready) rx_q.push_back(RLT_DST_TREQ);
    if (mrsp_valid && mrsp_ready) rx_q.push_back(RLT_DST_MNT);
    if (irsp_valid && irsp_ready) rxd_q.push_back({irsp_sop, irsp_eop, irsp_data});
    if (treq_valid && treq_ready) rxd_q.push_back({treq_sop, treq_eop, treq_data});
    if (mrsp_valid && mrsp_ready) rxd_q.push_back({mrsp_sop, mrsp_eop, mrsp_data});
    if (cfg_valid && cfg_ready) cfg_q.push_back({cfg_sop, cfg_eop, cfg_data});
    if (ltx_valid && ltx_ready) txm_q.push_back({ltx_sop, ltx_eop});
  end
  function automatic logic [63:0] mk(input logic [3:0] f, input logic [7:0] dst);
    return {4'h0, f, 16'h1234, 8'h00, 8'h00, dst, 16'hbeef};
  endfunction : mk
  function automatic logic [63:0] st(input logic [63:0] d);
    return {d[63:40], SID, d[31:0]};
  endfunction : st
  function automatic logic rdy(input int s);
    return (s == 0) ? ireq_ready : (s == 1) ? trsp_ready : mreq_ready;
  endfunction : rdy
  task automatic drv(input int s, input logic v, input logic sp, input logic ep,
                     input logic [63:0] d);
    case (s)
      0: {ireq_valid, ireq_sop, ireq_eop, ireq_data} = {v, sp, ep, d};
      1: {trsp_valid, trsp_sop, trsp_eop, trsp_data} = {v, sp, ep, d};
      default: {mreq_valid, mreq_sop, mreq_eop, mreq_data} = {v, sp, ep, d};
    endcase
  endtask : drv
  // one source beat, held until taken; the source goes idle for a cycle after eop
  task automatic put(input int s, input logic sp, input logic ep, input logic [63:0] d);
    int n;
    n = 0;
    drv(s, 1'b1, sp, ep, d);
    do begin
      @(posedge clk);
      n++;
    end while (!rdy(s) && n < 64);
    if (n >= 64) begin
      miscompares++;
      conclude();
    end
    #1;
    if (ep) begin
      drv(s, 1'b0, 1'b0, 1'b0, ~d);
      @(posedge clk);
      #1;
    end
  endtask : put
  // all three sources to the link under a stalling buffer, incl. doorbell and message
  task automatic t_tx_link;
    logic [63:0] e[6];
    logic [1:0] m[6];
    m = '{2'b10, 2'b01, 2'b11, 2'b11, 2'b11, 2'b11};
    e = '{st(mk(4'h5, 8'h11)), 64'hcafe, st(mk(4'hd, 8'h22)), st(mk(4'h8, 8'h33)),
          st(mk(4'ha, 8'h44)), st(mk(4'hb, 8'h55))};
    slow = 1'b1;
    put(0, 1'b1, 1'b0, mk(4'h5, 8'h11));
    put(0, 1'b0, 1'b1, 64'hcafe);
    put(1, 1'b1, 1'b1, mk(4'hd, 8'h22));
    put(2, 1'b1, 1'b1, mk(4'h8, 8'h33));
    put(0, 1'b1, 1'b1, mk(4'ha, 8'h44));
    put(0, 1'b1, 1'b1, mk(4'hb, 8'h55));
    `CHK(buf_m.tx_q.size(), 6)
    foreach (e[i]) begin
      `CHK(buf_m.tx_q.pop_front(), e[i])
      `CHK(txm_q.pop_front(), m[i])
    end
  endtask : t_tx_link
  // local config access from the user side goes to the config port, unstamped
  task automatic t_tx_local;
    put(0, 1'b1, 1'b0, mk(4'h8, SID));
    put(0, 1'b0, 1'b1, 64'h0123);
    `CHK(buf_m.tx_q.size(), 0)
    `CHK(cfg_q.size(), 2)
    `CHK(cfg_q.pop_front(), {2'b10, mk(4'h8, SID)})
    `CHK(cfg_q.pop_front(), {2'b01, 64'h0123})
  endtask : t_tx_local
  // every format type lands on exactly one sink; a busy sink stalls the link
  task automatic t_rx_route;
    rlt_dst_t ed;
    for (int f = 0; f < 16; f++) begin
      ed = (f[3:0] == RLT_FT_RESP) ? RLT_DST_IRSP : (f[3:0] == RLT_FT_MAINT) ? RLT_DST_MNT :
           RLT_DST_TREQ;
      buf_m.send(1'b1, 1'b1, mk(f[3:0], 8'h66), ok);
      `CHK(ok, 1'b1)
      if (!ok) conclude();
      `CHK(rx_q.size(), 1)
      `CHK(rx_q.pop_front(), ed)
      `CHK(rxd_q.pop_front(), {2'b11, mk(f[3:0], 8'h66)})
    end
    treq_ready = 1'b0;
    fork
      buf_m.send(1'b1, 1'b1, mk(4'h6, 8'h67), ok);
      begin
        repeat (3) @(posedge clk);
        `CHK(lrx_ready, 1'b0)
        #1 treq_ready = 1'b1;
      end
    join
    `CHK(ok, 1'b1)
    if (!ok) conclude();
    `CHK(rx_q.size(), 1)
    `CHK(rx_q.pop_front(), RLT_DST_TREQ)
    `CHK(rxd_q.pop_front(), {2'b11, mk(4'h6, 8'h67)})
  endtask : t_rx_route
  // two sources and an inbound packet at once: response first, nothing blocks
  task automatic t_concurrent;
    fork
      put(0, 1'b1, 1'b1, mk(4'h2, 8'h77));
      put(1, 1'b1, 1'b1, mk(4'hd, 8'h78));
      buf_m.send(1'b1, 1'b1, mk(4'hd, 8'h79), ok);
    join
    `CHK(ok, 1'b1)
    if (!ok) conclude();
    `CHK(buf_m.tx_q.pop_front(), st(mk(4'hd, 8'h78)))
    `CHK(txm_q.pop_front(), 2'b11)
    `CHK(buf_m.tx_q.pop_front(), st(mk(4'h2, 8'h77)))
    `CHK(rx_q.pop_front(), RLT_DST_IRSP)
    `CHK(rxd_q.pop_front(), {2'b11, mk(4'hd, 8'h79)})
  endtask : t_concurrent
  task automatic conclude;
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  initial begin
    drv(0, 1'b0, 1'b0, 1'b0, 64'h0);
    drv(1, 1'b0, 1'b0, 1'b0, 64'h0);
    drv(2, 1'b0, 1'b0, 1'b0, 64'h0);
    {irsp_ready, treq_ready, mrsp_ready, cfg_ready} = 4'hf;
    repeat (20) @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk);
    #1;
    t_tx_link();
    t_tx_local();
    t_rx_route();
    t_concurrent();
    conclude();
  end
endmodule : rlt_router_test
